// ===== design/sil1c_map.svh
/*
  Register offsets, field positions, reset values, codes and timing figures
  of the S-interface layer 1 control block. Included by the top only.
*/
`ifndef SIL1C_MAP_SVH
`define SIL1C_MAP_SVH

`define SIL1C_CMD_OFS       5'h00
`define SIL1C_IND_OFS       5'h04
`define SIL1C_SQS_OFS       5'h08
`define SIL1C_SQX_OFS       5'h0C
`define SIL1C_DST_OFS       5'h10

`define SIL1C_SQS_LOCK_BIT  4
`define SIL1C_SQS_CHG_BIT   5
`define SIL1C_SQX_MFD_BIT   4
`define SIL1C_CMD_RST_VAL   4'h0
`define SIL1C_SQX_RST_VAL   5'h00

`define SIL1C_C_DDR         4'h0
`define SIL1C_C_RST         4'h1
`define SIL1C_C_SSP         4'h2
`define SIL1C_C_SCP         4'h3
`define SIL1C_C_ARD         4'h8
`define SIL1C_C_ACTIVATE_PRIO_HIGH_CMD        4'h9
`define SIL1C_C_DRA         4'hF

`define SIL1C_I_TI          4'h0
`define SIL1C_I_RESET_STATE_INDICATION        4'h1
`define SIL1C_I_RESYNC_INDICATION        4'h4
`define SIL1C_I_ACTIVATE_REQUEST_INDICATION        4'h8
`define SIL1C_I_AI8         4'hC
`define SIL1C_I_AI10        4'hD
`define SIL1C_I_DEACTIVATION_REQUEST_INDICATION        4'hF

`define SIL1C_CLK_HZ        50000000
`define SIL1C_INFO0_MS      16
`define SIL1C_TIMER2_MS     25
`define SIL1C_CONT_HZ       96000
`define SIL1C_SINGLE_US     250
`define SIL1C_LOSS_FRAMES   2
`define SIL1C_REGAIN_FRAMES 5
`define SIL1C_MF_FRAMES     20

`endif

// ===== design/sil1c_pkg.sv
/*
  Types of the S-interface layer 1 control block.
  Assumes sil1c_map.svh is on the include path.
*/
package sil1c_pkg;
  typedef enum logic [1:0] {
    RX_INFO0 = 2'h0,
    RX_INFO1 = 2'h1,
    RX_INFO3 = 2'h2,
    RX_OTHER = 2'h3
  } sil1c_rx_info_type;

  typedef enum logic [1:0] {
    TX_INFO0 = 2'h0,
    TX_INFO2 = 2'h1,
    TX_INFO4 = 2'h2,
    TX_TEST  = 2'h3
  } sil1c_tx_info_type;

  typedef enum logic [7:0] {
    ST_G1_DEACT   = 8'h01,
    ST_G2_PEND    = 8'h02,
    ST_G3_ACT     = 8'h04,
    ST_G4_PDEACT  = 8'h08,
    ST_G4_AWAIT   = 8'h10,
    ST_TEST_CONT  = 8'h20,
    ST_TEST_SINGL = 8'h40,
    ST_RESET      = 8'h80
  } sil1c_state_type;

  typedef struct packed {
    logic              frame_stb;
    sil1c_rx_info_type info;
    logic              frame_ok;
    logic              fa_bit;
    logic              m_bit;
    logic              s_bit;
  } sil1c_line_rx_type;

  typedef struct packed {
    logic bit_stb;
    logic tx_active;
    logic tx_bit;
    logic echo_bit;
    logic prio_lower;
  } sil1c_dch_type;
endpackage

// ===== design/sil1c_top.sv
/*
  Network-side layer 1 control: activation state machine, command and
  indication codes, D-channel collision and priority, frame alignment and
  S/Q multiframe handling, with AXI4-Lite registers.
  Assumes line inputs are decoded per frame and synchronous to MCLK_I.
*/
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
// Notes on behaviour
// - INFO1 or activate command: pend, send INFO2
// - INFO3 while pending: activated, send INFO4
// - sync lost when active: INFO2 until regained
// - deactivate: request after INFO0 16ms or timer2
// - deactivation acknowledge returns to deactivated
// - test modes: 96 kHz or 2 kHz pulses
// - commands 1000 activate, 0000 deactivate, 1111 ack
// - test commands 0011 continuous, 0010 single
// - command 0001 resets to pending-deact or reset state
// - indications 0100 resync, 1000 INFO1, 1100 sync
// - indications 1111 deact request, 0001 reset, 0000 test
// - collision stops D transmission, then watch echo
// - priority class via 1000 or 1001
// - activation indication 1100 or 1101 by class
// - one bad frame keeps alignment
// - FA bit mirrored even for bad frames
// - two consecutive bad frames lose alignment
// - alignment regained on fifth good frame
// - multiframe lock after 20 correct M frames
// - locked: store S1-S4, flag any change
// - locked: send Q1-Q4, otherwise mirror FA
// - control bit disables multiframe lock
// - command and indication codes held until replaced
`include "sil1c_map.svh"

module sil1c_top #(
  parameter int unsigned INFO0_CYC  = `SIL1C_INFO0_MS * (`SIL1C_CLK_HZ / 1000),
  parameter int unsigned TIMER2_CYC = `SIL1C_TIMER2_MS * (`SIL1C_CLK_HZ / 1000),
  parameter int unsigned GAP_CYC    = `SIL1C_SINGLE_US * (`SIL1C_CLK_HZ / 1000000)
) (
  input  wire logic                        MCLK_I,
  input  wire logic                        ARST_N_I,
  input  wire logic [4:0]                  AXI_AWADDR_I,
  input  wire logic                        AXI_AWVALID_I,
  output logic                             AXI_AWREADY_O,
  input  wire logic [31:0]                 AXI_WDATA_I,
  input  wire logic [3:0]                  AXI_WSTRB_I,
  input  wire logic                        AXI_WVALID_I,
  output logic                             AXI_WREADY_O,
  output logic [1:0]                       AXI_BRESP_O,
  output logic                             AXI_BVALID_O,
  input  wire logic                        AXI_BREADY_I,
  input  wire logic [4:0]                  AXI_ARADDR_I,
  input  wire logic                        AXI_ARVALID_I,
  output logic                             AXI_ARREADY_O,
  output logic [31:0]                      AXI_RDATA_O,
  output logic [1:0]                       AXI_RRESP_O,
  output logic                             AXI_RVALID_O,
  input  wire logic                        AXI_RREADY_I,
  input  wire sil1c_pkg::sil1c_line_rx_type LINE_RX_I,
  input  wire sil1c_pkg::sil1c_dch_type     DCH_I,
  output sil1c_pkg::sil1c_tx_info_type      TX_INFO_O,
  output logic                             TX_FA_O,
  output logic                             PULSE_POS_O,
  output logic                             PULSE_NEG_O,
  output logic                             D_TX_EN_O,
  output logic                             CLK_EN_O,
  output logic                             S_CHANGE_O
);
  import sil1c_pkg::*;

  localparam int unsigned BIT_CYC = `SIL1C_CLK_HZ / (2 * `SIL1C_CONT_HZ);

  function automatic logic q_slot(input logic [4:0] pos);
    q_slot = (pos == 5'd0) || (pos == 5'd5) || (pos == 5'd10) || (pos == 5'd15);
  endfunction

  function automatic logic [1:0] slot_idx(input logic [4:0] pos);
    slot_idx = 2'(pos / 5'd5);
  endfunction

  logic [3:0]        cmd_q;
  logic [3:0]        ind_q;
  logic [3:0]        ind_d;
  logic [3:0]        s_bits_q;
  logic              s_chg_q;
  logic [4:0]        sqx_q;
  logic              prio_hi_q;
  sil1c_state_type   state_q;
  sil1c_state_type   state_d;
  logic [31:0]       info0_cnt_q;
  logic [31:0]       t2_cnt_q;
  logic              align_q;
  logic [2:0]        bad_cnt_q;
  logic [2:0]        good_cnt_q;
  logic              mf_lock_q;
  logic [4:0]        mf_pos_q;
  logic [4:0]        mf_cnt_q;
  logic              d_block_q;
  logic [3:0]        ones_q;
  logic [13:0]       pcnt_q;
  logic              pol_q;
  logic              wr_go;
  logic              rd_go;
  logic              frame;
  logic [4:0]        pos_n;
  logic              m_exp;
  logic              s_capture;
  logic [3:0]        prio_need;

  // ---------------- AXI4-Lite slave ----------------
  assign wr_go         = AXI_AWVALID_I && AXI_WVALID_I && !AXI_BVALID_O;
  assign AXI_AWREADY_O = wr_go;
  assign AXI_WREADY_O  = wr_go;
  assign rd_go         = AXI_ARVALID_I && !AXI_RVALID_O;
  assign AXI_ARREADY_O = rd_go;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O  <= 2'h0;
    end else if (wr_go) begin
      AXI_BVALID_O <= 1'b1;
      AXI_BRESP_O  <= (AXI_AWADDR_I == `SIL1C_CMD_OFS || AXI_AWADDR_I == `SIL1C_SQS_OFS ||
                       AXI_AWADDR_I == `SIL1C_SQX_OFS) ? 2'h0 : 2'h2;
    end else if (AXI_BREADY_I) begin
      AXI_BVALID_O <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AXI_RVALID_O <= 1'b0;
      AXI_RRESP_O  <= 2'h0;
      AXI_RDATA_O  <= 32'h0;
    end else if (rd_go) begin
      AXI_RVALID_O <= 1'b1;
      AXI_RRESP_O  <= 2'h0;
      unique case (AXI_ARADDR_I)
        `SIL1C_CMD_OFS: AXI_RDATA_O <= {28'h0, cmd_q};
        `SIL1C_IND_OFS: AXI_RDATA_O <= {28'h0, ind_q};
        `SIL1C_SQS_OFS: AXI_RDATA_O <= {26'h0, s_chg_q, mf_lock_q, s_bits_q};
        `SIL1C_SQX_OFS: AXI_RDATA_O <= {27'h0, sqx_q};
        `SIL1C_DST_OFS: AXI_RDATA_O <= {29'h0, align_q, d_block_q, prio_hi_q};
        default: begin
          AXI_RDATA_O <= 32'h0;
          AXI_RRESP_O <= 2'h2;
        end
      endcase
    end else if (AXI_RREADY_I) begin
      AXI_RVALID_O <= 1'b0;
    end
  end

  // code stays until software writes another one
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      cmd_q <= `SIL1C_CMD_RST_VAL;
    end else if (wr_go && AXI_AWADDR_I == `SIL1C_CMD_OFS && AXI_WSTRB_I[0]) begin
      cmd_q <= AXI_WDATA_I[3:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sqx_q <= `SIL1C_SQX_RST_VAL;
    end else if (wr_go && AXI_AWADDR_I == `SIL1C_SQX_OFS && AXI_WSTRB_I[0]) begin
      sqx_q <= AXI_WDATA_I[4:0];
    end
  end

  // priority class follows the last activate command
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      prio_hi_q <= 1'b0;
    end else if (cmd_q == `SIL1C_C_ARD) begin
      prio_hi_q <= 1'b0;
    end else if (cmd_q == `SIL1C_C_ACTIVATE_PRIO_HIGH_CMD) begin
      prio_hi_q <= 1'b1;
    end
  end

  // ---------------- activation state machine ----------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_G1_DEACT: begin
        if (cmd_q == `SIL1C_C_RST) state_d = ST_RESET;
        else if (cmd_q == `SIL1C_C_SCP) state_d = ST_TEST_CONT;
        else if (cmd_q == `SIL1C_C_SSP) state_d = ST_TEST_SINGL;
        else if (cmd_q == `SIL1C_C_ARD || cmd_q == `SIL1C_C_ACTIVATE_PRIO_HIGH_CMD ||
                 LINE_RX_I.info == RX_INFO1) state_d = ST_G2_PEND;
      end
      ST_G2_PEND: begin
        if (cmd_q == `SIL1C_C_RST) state_d = ST_G4_PDEACT;
        else if (cmd_q == `SIL1C_C_DDR) state_d = ST_G4_PDEACT;
        else if (LINE_RX_I.info == RX_INFO3 && align_q) state_d = ST_G3_ACT;
      end
      ST_G3_ACT: begin
        if (cmd_q == `SIL1C_C_RST || cmd_q == `SIL1C_C_DDR) state_d = ST_G4_PDEACT;
      end
      ST_G4_PDEACT: begin
        if (cmd_q == `SIL1C_C_RST) state_d = ST_RESET;
        else if ((LINE_RX_I.info == RX_INFO0 && info0_cnt_q >= INFO0_CYC - 1) ||
                 t2_cnt_q >= TIMER2_CYC - 1) state_d = ST_G4_AWAIT;
      end
      ST_G4_AWAIT: begin
        if (cmd_q == `SIL1C_C_RST) state_d = ST_RESET;
        else if (cmd_q == `SIL1C_C_DRA) state_d = ST_G1_DEACT;
      end
      ST_TEST_CONT: begin
        if (cmd_q != `SIL1C_C_SCP) state_d = ST_G1_DEACT;
      end
      ST_TEST_SINGL: begin
        if (cmd_q != `SIL1C_C_SSP) state_d = ST_G1_DEACT;
      end
      ST_RESET: begin
        if (cmd_q != `SIL1C_C_RST) state_d = ST_G1_DEACT;
      end
      default: state_d = ST_G1_DEACT;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) state_q <= ST_G1_DEACT;
    else state_q <= state_d;
  end

  // both deactivation timers start fresh on entry to pending deactivation
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      info0_cnt_q <= 32'h0;
      t2_cnt_q    <= 32'h0;
    end else if (state_q != ST_G4_PDEACT) begin
      info0_cnt_q <= 32'h0;
      t2_cnt_q    <= 32'h0;
    end else begin
      t2_cnt_q    <= t2_cnt_q + 32'h1;
      info0_cnt_q <= (LINE_RX_I.info == RX_INFO0) ? info0_cnt_q + 32'h1 : 32'h0;
    end
  end

  always_comb begin
    ind_d = `SIL1C_I_DEACTIVATION_REQUEST_INDICATION;
    unique case (state_q)
      ST_G2_PEND: ind_d = (LINE_RX_I.info == RX_INFO1) ? `SIL1C_I_ACTIVATE_REQUEST_INDICATION : `SIL1C_I_RESYNC_INDICATION;
      ST_G3_ACT: begin
        if (!align_q) ind_d = `SIL1C_I_RESYNC_INDICATION;
        else ind_d = prio_hi_q ? `SIL1C_I_AI10 : `SIL1C_I_AI8;
      end
      ST_G4_PDEACT: ind_d = `SIL1C_I_RESYNC_INDICATION;
      ST_TEST_CONT, ST_TEST_SINGL: ind_d = `SIL1C_I_TI;
      ST_RESET: ind_d = `SIL1C_I_RESET_STATE_INDICATION;
      default: ind_d = `SIL1C_I_DEACTIVATION_REQUEST_INDICATION;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) ind_q <= `SIL1C_I_DEACTIVATION_REQUEST_INDICATION;
    else ind_q <= ind_d;
  end

  // G1 held by the deactivate command stops the internal clocks
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      TX_INFO_O <= TX_INFO0;
      CLK_EN_O  <= 1'b0;
    end else begin
      CLK_EN_O <= !(state_d == ST_G1_DEACT && cmd_q == `SIL1C_C_DDR);
      unique case (state_d)
        ST_G2_PEND: TX_INFO_O <= TX_INFO2;
        ST_G3_ACT: TX_INFO_O <= align_q ? TX_INFO4 : TX_INFO2;
        ST_TEST_CONT, ST_TEST_SINGL: TX_INFO_O <= TX_TEST;
        default: TX_INFO_O <= TX_INFO0;
      endcase
    end
  end

  // ---------------- test pulses ----------------
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pcnt_q      <= 14'h0;
      pol_q       <= 1'b0;
      PULSE_POS_O <= 1'b0;
      PULSE_NEG_O <= 1'b0;
    end else if (state_q == ST_TEST_CONT) begin
      pcnt_q      <= (pcnt_q == 14'(BIT_CYC - 1)) ? 14'h0 : pcnt_q + 14'h1;
      pol_q       <= (pcnt_q == 14'(BIT_CYC - 1)) ? !pol_q : pol_q;
      PULSE_POS_O <= !pol_q;
      PULSE_NEG_O <= pol_q;
    end else if (state_q == ST_TEST_SINGL) begin
      pcnt_q      <= (pcnt_q == 14'(GAP_CYC - 1)) ? 14'h0 : pcnt_q + 14'h1;
      pol_q       <= (pcnt_q == 14'(GAP_CYC - 1)) ? !pol_q : pol_q;
      PULSE_POS_O <= (pcnt_q < 14'(BIT_CYC)) && !pol_q;
      PULSE_NEG_O <= (pcnt_q < 14'(BIT_CYC)) && pol_q;
    end else begin
      pcnt_q      <= 14'h0;
      PULSE_POS_O <= 1'b0;
      PULSE_NEG_O <= 1'b0;
    end
  end

  // ---------------- D channel access ----------------
  assign prio_need = (prio_hi_q ? 4'hA : 4'h8) + {3'h0, DCH_I.prio_lower};

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      d_block_q <= 1'b0;
      ones_q    <= 4'h0;
    end else if (DCH_I.bit_stb) begin
      if (DCH_I.tx_active && !d_block_q && DCH_I.tx_bit != DCH_I.echo_bit) begin
        d_block_q <= 1'b1;
        ones_q    <= 4'h0;
      end else if (d_block_q) begin
        ones_q    <= DCH_I.echo_bit ? ones_q + 4'h1 : 4'h0;
        d_block_q <= !(DCH_I.echo_bit && ones_q + 4'h1 >= prio_need);
      end
    end
  end

  // a collision cuts transmission in the same cycle
  assign D_TX_EN_O = !d_block_q &&
                     !(DCH_I.bit_stb && DCH_I.tx_active && DCH_I.tx_bit != DCH_I.echo_bit);

  // ---------------- frame alignment ----------------
  assign frame = LINE_RX_I.frame_stb;

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      align_q    <= 1'b0;
      bad_cnt_q  <= 3'h0;
      good_cnt_q <= 3'h0;
    end else if (frame) begin
      if (align_q) begin
        bad_cnt_q <= LINE_RX_I.frame_ok ? 3'h0 : bad_cnt_q + 3'h1;
        if (!LINE_RX_I.frame_ok && bad_cnt_q == 3'(`SIL1C_LOSS_FRAMES - 1)) begin
          align_q    <= 1'b0;
          good_cnt_q <= 3'h0;
        end
      end else begin
        good_cnt_q <= LINE_RX_I.frame_ok ? good_cnt_q + 3'h1 : 3'h0;
        if (LINE_RX_I.frame_ok && good_cnt_q == 3'(`SIL1C_REGAIN_FRAMES - 1)) begin
          align_q   <= 1'b1;
          bad_cnt_q <= 3'h0;
        end
      end
    end
  end

  // ---------------- multiframe ----------------
  assign pos_n     = (mf_pos_q == 5'(`SIL1C_MF_FRAMES - 1)) ? 5'h0 : mf_pos_q + 5'h1;
  assign m_exp     = (pos_n == 5'h0);
  assign s_capture = frame && mf_lock_q && q_slot(pos_n);

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      mf_lock_q <= 1'b0;
      mf_pos_q  <= 5'h0;
      mf_cnt_q  <= 5'h0;
    end else if (sqx_q[`SIL1C_SQX_MFD_BIT]) begin
      mf_lock_q <= 1'b0;
      mf_cnt_q  <= 5'h0;
    end else if (frame) begin
      if (mf_cnt_q != 5'h0 && LINE_RX_I.m_bit == m_exp) begin
        mf_pos_q <= pos_n;
        if (mf_cnt_q == 5'(`SIL1C_MF_FRAMES - 1)) mf_lock_q <= 1'b1;
        if (mf_cnt_q != 5'(`SIL1C_MF_FRAMES)) mf_cnt_q <= mf_cnt_q + 5'h1;
      end else begin
        mf_lock_q <= 1'b0;
        mf_pos_q  <= 5'h0;
        mf_cnt_q  <= LINE_RX_I.m_bit ? 5'h1 : 5'h0;
      end
    end
  end

  // the change flag set beats a software clear in the same cycle
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_bits_q   <= 4'h0;
      s_chg_q    <= 1'b0;
      S_CHANGE_O <= 1'b0;
    end else begin
      S_CHANGE_O <= s_capture && (s_bits_q[slot_idx(pos_n)] != LINE_RX_I.s_bit);
      if (s_capture) s_bits_q[slot_idx(pos_n)] <= LINE_RX_I.s_bit;
      if (s_capture && s_bits_q[slot_idx(pos_n)] != LINE_RX_I.s_bit) s_chg_q <= 1'b1;
      else if (wr_go && AXI_AWADDR_I == `SIL1C_SQS_OFS && AXI_WDATA_I[`SIL1C_SQS_CHG_BIT])
        s_chg_q <= 1'b0;
    end
  end

  // FA of the outgoing frame is decided at the incoming frame strobe
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) TX_FA_O <= 1'b0;
    else if (frame) begin
      if (mf_lock_q && LINE_RX_I.m_bit == m_exp && q_slot(pos_n))
        TX_FA_O <= sqx_q[slot_idx(pos_n)];
      else TX_FA_O <= LINE_RX_I.fa_bit;
    end
  end

  // ---------------- checks ----------------
  a_pend_sends_info2: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    state_q == ST_G1_DEACT && cmd_q == `SIL1C_C_ARD |=> TX_INFO_O == TX_INFO2)
    else $error("activate command did not start INFO2");
  a_act_sends_info4: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    state_q == ST_G2_PEND && LINE_RX_I.info == RX_INFO3 && align_q && cmd_q == `SIL1C_C_ARD
    |=> state_q == ST_G3_ACT && TX_INFO_O == TX_INFO4)
    else $error("INFO3 did not activate with INFO4");
  a_lost_sync_info2: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    state_q == ST_G3_ACT && $fell(align_q) && cmd_q != `SIL1C_C_DDR && cmd_q != `SIL1C_C_RST
    |=> TX_INFO_O == TX_INFO2)
    else $error("INFO4 kept after sync loss");
  a_deact_request: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    state_q == ST_G4_PDEACT && cmd_q == `SIL1C_C_DDR && t2_cnt_q == TIMER2_CYC - 1
    |=> state_q == ST_G4_AWAIT ##1 ind_q == `SIL1C_I_DEACTIVATION_REQUEST_INDICATION)
    else $error("timer2 expiry gave no deactivation request");
  a_ack_returns: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    state_q == ST_G4_AWAIT && cmd_q == `SIL1C_C_DRA |=> state_q == ST_G1_DEACT)
    else $error("acknowledge did not return to deactivated");
  a_cont_pulses: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    state_q == ST_TEST_CONT [*3] |-> PULSE_POS_O != PULSE_NEG_O)
    else $error("continuous pulses missing");
  a_reset_ind: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    state_q == ST_RESET && $past(state_q) == ST_RESET |-> ind_q == `SIL1C_I_RESET_STATE_INDICATION)
    else $error("reset indication wrong");
  a_collision_stop: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    DCH_I.bit_stb && DCH_I.tx_active && DCH_I.tx_bit != DCH_I.echo_bit
    |-> !D_TX_EN_O ##1 !D_TX_EN_O)
    else $error("collision did not stop D transmission");
  a_align_loss: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    align_q && frame && !LINE_RX_I.frame_ok && bad_cnt_q == 3'h1 |=> !align_q)
    else $error("second bad frame kept alignment");
  a_align_keep: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    align_q && frame && !LINE_RX_I.frame_ok && bad_cnt_q == 3'h0 |=> align_q)
    else $error("single bad frame lost alignment");
  a_align_regain: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    !align_q && frame && LINE_RX_I.frame_ok && good_cnt_q == 3'h4 |=> align_q)
    else $error("fifth good frame did not regain");
  a_mf_disable: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    sqx_q[`SIL1C_SQX_MFD_BIT] |=> !mf_lock_q)
    else $error("multiframe locked while disabled");
  a_fa_mirror: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I)
    frame && !mf_lock_q |=> TX_FA_O == $past(LINE_RX_I.fa_bit))
    else $error("FA not mirrored while unlocked");
endmodule

// ===== verification/sil1c_te_model.sv
/*
  Terminal-side line model: one decoded frame every 16 clocks, 20-frame multiframe.
  Assumes the bench sets info, frame quality and S pattern between frames.
*/
module sil1c_te_model (
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  input  wire sil1c_pkg::sil1c_rx_info_type  info_i,
  input  wire logic                          ok_i,
  input  wire logic [3:0]                    s_pat_i,
  output sil1c_pkg::sil1c_line_rx_type       rx_o
);
  import sil1c_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] tick_q;
  logic [4:0] pos_q;
  logic       slot;
  // fa/s slots at frames 1, 6, 11, 16 of the multiframe
  assign slot = (pos_q == 5'h00) || (pos_q == 5'h05) || (pos_q == 5'h0A) || (pos_q == 5'h0F);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_q <= 4'h0;
      pos_q  <= 5'h00;
      rx_o   <= '0;
    end else begin
      tick_q <= tick_q + 4'h1;
      rx_o.frame_stb <= (tick_q == 4'hF);
      rx_o.info      <= info_i;
      if (tick_q == 4'hF) begin
        pos_q         <= (pos_q == 5'h13) ? 5'h00 : pos_q + 5'h01;
        rx_o.frame_ok <= ok_i;
        rx_o.fa_bit   <= slot;
        rx_o.m_bit    <= (pos_q == 5'h00);
        rx_o.s_bit    <= slot & s_pat_i[pos_q / 5];
      end
    end
  end
endmodule

// ===== verification/s_interface_layer1_control_tb_top.sv
/*
  Self-checking bench: AXI4-Lite master, line model, read-data scoreboard.
  Assumes the small timer parameters set at the instance below.
*/
module s_interface_layer1_control_tb_top;
  import sil1c_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, ok = 1'b0, fa, pp, pn, den, cen, sch;
  logic [4:0]  awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0]  bresp, rresp;
  logic [3:0]  s_pat = 4'h0;
  logic [33:0] exp_q[$], msk_q[$], e, m;
  sil1c_rx_info_type info = RX_INFO0;
  sil1c_tx_info_type txi;
  sil1c_line_rx_type rx;
  sil1c_dch_type     dch = '0;
  int errors = 0, cmp_count = 0, cyc = 0;
  always #10 clk = ~clk;
  sil1c_te_model te (.clk_i(clk), .rst_n_i(rst_n), .info_i(info), .ok_i(ok),
    .s_pat_i(s_pat), .rx_o(rx));
  sil1c_top #(.INFO0_CYC(40), .TIMER2_CYC(100), .GAP_CYC(600)) uut (
    .MCLK_I(clk), .ARST_N_I(rst_n), .AXI_AWADDR_I(awa), .AXI_AWVALID_I(awv),
    .AXI_AWREADY_O(awr), .AXI_WDATA_I(wd), .AXI_WSTRB_I(4'hF), .AXI_WVALID_I(wv),
    .AXI_WREADY_O(wr_rdy), .AXI_BRESP_O(bresp), .AXI_BVALID_O(bv), .AXI_BREADY_I(br),
    .AXI_ARADDR_I(ara), .AXI_ARVALID_I(arv), .AXI_ARREADY_O(arr), .AXI_RDATA_O(rd),
    .AXI_RRESP_O(rresp), .AXI_RVALID_O(rv), .AXI_RREADY_I(rr), .LINE_RX_I(rx),
    .DCH_I(dch), .TX_INFO_O(txi), .TX_FA_O(fa), .PULSE_POS_O(pp), .PULSE_NEG_O(pn),
    .D_TX_EN_O(den), .CLK_EN_O(cen), .S_CHANGE_O(sch));
  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    cmp_count++;
    if (seen !== want) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // returns at the edge where the design takes a frame strobe
  task automatic wait_frame();
    do @(posedge clk); while (rx.frame_stb !== 1'b1);
  endtask
  // write: address and data offered together, both taken at the same edge
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do @(posedge clk); while (awr !== 1'b1);
    awv <= 1'b0; wv <= 1'b0;
    do @(posedge clk); while (bv !== 1'b1);
    br <= 1'b0;
  endtask
  // read: the expected word and its mask are noted before the request goes out
  task automatic axi_rd(input logic [4:0] a, input logic [33:0] want, input logic [33:0] k);
    exp_q.push_back(want); msk_q.push_back(k);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rv === 1'b1 && rr === 1'b1) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      check({rresp, rd} & m, e);
    end
  end
  // random bit strobes with D bit and echo both 0, so no collision blocks the channel
  always @(posedge clk) begin
    cyc++;
    dch <= {1'($urandom_range(1)), 1'b1, 2'b00, 1'b0};
    if (cyc > 20000) begin
      errors++;
      stop_test();
    end
  end
  localparam logic [33:0] ALL = 34'h3FFFFFFFF;
  initial begin
    void'($urandom(32'hEEA9));
    s_pat = 4'($urandom());
    wait_cyc(3);
    rst_n <= 1'b1;
    axi_rd(5'h00, 34'h0, ALL);
    check(34'(cen), 34'h0);
    axi_rd(5'h04, 34'hF, ALL);
    axi_rd(5'h14, 34'h200000000, ALL);
    axi_wr(5'h00, 32'h8);
    wait_cyc(4);
    check(34'(txi), 34'(TX_INFO2));
    info <= RX_INFO3; ok <= 1'b1;
    wait_cyc(700);
    check(34'(txi), 34'(TX_INFO4));
    axi_rd(5'h04, 34'hC, ALL);
    axi_rd(5'h08, 34'({1'b1, s_pat}), 34'h1F);
    check(34'(sch === 1'b0), 34'h1);
    wait_frame();
    ok <= 1'b0;
    wait_frame();
    wait_cyc(2);
    check(34'(txi), 34'(TX_INFO4));
    wait_frame();
    wait_cyc(2);
    check(34'(txi), 34'(TX_INFO2));
    ok <= 1'b1;
    wait_cyc(60);
    check(34'(txi), 34'(TX_INFO2));
    wait_cyc(40);
    check(34'(txi), 34'(TX_INFO4));
    axi_wr(5'h00, 32'h0);
    axi_rd(5'h04, 34'h4, ALL);
    info <= RX_INFO0;
    wait_cyc(60);
    axi_rd(5'h04, 34'hF, ALL);
    axi_wr(5'h00, 32'hF);
    wait_cyc(4);
    check(34'(txi), 34'(TX_INFO0));
    check(34'(cen), 34'h1);
    axi_wr(5'h00, 32'h9);
    info <= RX_INFO3;
    wait_cyc(150);
    axi_rd(5'h04, 34'hD, ALL);
    axi_rd(5'h10, 34'h1, 34'h1);
    axi_wr(5'h00, 32'h1);
    wait_cyc(4);
    axi_rd(5'h04, 34'h1, ALL);
    axi_wr(5'h00, 32'h3);
    wait_cyc(4);
    check(34'(txi), 34'(TX_TEST));
    check(34'(pp ^ pn), 34'h1);
    check(34'(den), 34'h1);
    stop_test();
  end
endmodule
